// ===== hdl/flash_ctrl_pkg.sv
package flash_ctrl_pkg;

    // ------------------------------------------------------------
    // Register map (word addresses on Avalon-MM)
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_CONTROL_ADDR = 2'h0;
    localparam logic [1:0] ERROR_STATUS_ADDR = 2'h1;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int HW_WE_BIT = 7;
    localparam int SW_WE_BIT = 6;
    localparam int ERASE_SETUP_BIT = 5;
    localparam int PROGRAM_SETUP_BIT = 4;
    localparam int ERASE_VERIFY_BIT = 3;
    localparam int PROGRAM_VERIFY_BIT = 2;
    localparam int ERASE_MODE_BIT = 1;
    localparam int PROGRAM_MODE_BIT = 0;
    localparam int FLASH_ERROR_BIT = 7;

    // ------------------------------------------------------------
    // Reset and fixed values
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_HW_HIGH_VALUE = 8'h80;
    localparam logic [7:0] CONTROL_HW_LOW_VALUE = 8'h00;
    localparam logic [7:0] STATUS_RESET_VALUE = 8'h00;
    localparam logic [7:0] DISABLED_READ_VALUE = 8'h00;
    localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h00000000;
    localparam logic [16:0] FLASH_LAST_ADDR = 17'h1FFFF;

    // Bus answer latency: one wait cycle before waitrequest drops
    localparam int BUS_WAIT_CYCLES = 1;

    // Control bits 6..0 held in the register
    typedef struct packed {
        logic sw_write_enable;
        logic erase_setup;
        logic program_setup;
        logic erase_verify;
        logic program_verify;
        logic erase_mode;
        logic program_mode;
    } mode_bits_type;

    // Events that trip error protection during program/erase; exempt_exception instead masks exception_start
    typedef struct packed {
        logic flash_read;
        logic exception_start;
        logic exempt_exception;
        logic sleep_exec;
        logic bus_release;
    } cpu_event_type;

    // Flash array control outputs
    typedef struct packed {
        logic program_active;
        logic erase_active;
        logic program_verify_active;
        logic erase_verify_active;
    } array_ctrl_type;

    typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_DONE} bus_state_type;

endpackage

// ===== hdl/flash_program_erase_control.sv
// The Avalon-MM register port and the register offsets are this design's own decisions.
module flash_program_erase_control (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic watchdog_reset,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic flash_enabled,
    input wire logic hw_write_enable,
    input wire flash_ctrl_pkg::cpu_event_type cpu_event,
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output flash_ctrl_pkg::array_ctrl_type array_ctrl,
    output logic flash_error
);

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    flash_ctrl_pkg::bus_state_type bus_state_r;
    logic [31:0] readdata_r;
    logic access_done;
    logic write_take;

    // One wait state, then the request is answered and completes
    assign access_done = (bus_state_r == flash_ctrl_pkg::BUS_WAIT);
    assign avs_waitrequest = (avs_read | avs_write) & ~access_done;
    assign write_take = avs_write & access_done & avs_byteenable[0];
    assign avs_readdata = readdata_r;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bus_state_r <= flash_ctrl_pkg::BUS_IDLE;
        end
        else
        begin
            case (bus_state_r)
                flash_ctrl_pkg::BUS_IDLE:
                begin
                    if (avs_read | avs_write)
                    begin
                        bus_state_r <= flash_ctrl_pkg::BUS_WAIT;
                    end
                end
                flash_ctrl_pkg::BUS_WAIT:
                begin
                    bus_state_r <= flash_ctrl_pkg::BUS_DONE;
                end
                flash_ctrl_pkg::BUS_DONE:
                begin
                    bus_state_r <= flash_ctrl_pkg::BUS_IDLE;
                end
                default:
                begin
                    bus_state_r <= flash_ctrl_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Mode control register
    // ------------------------------------------------------------
    flash_ctrl_pkg::mode_bits_type mode_r;
    flash_ctrl_pkg::mode_bits_type mode_nxt;
    logic error_r;
    logic standby_init;
    logic hw_we_r;
    logic [7:0] wr_byte;

    // Standby modes reinitialise the register like a reset
    assign standby_init = hw_standby | sw_standby;
    assign wr_byte = avs_writedata[7:0];

    function automatic logic control_write(
        input logic [1:0] addr,
        input logic wr,
        input logic en
    );
        control_write = wr & en
            & (addr == flash_ctrl_pkg::MODE_CONTROL_ADDR);
    endfunction

    always_comb
    begin
        mode_nxt = mode_r;
        if (control_write(avs_address, write_take, flash_enabled))
        begin
            // Software enable gated by the hardware pin
            if (hw_write_enable)
            begin
                mode_nxt.sw_write_enable =
                    wr_byte[flash_ctrl_pkg::SW_WE_BIT];
            end
            if (hw_write_enable & mode_r.sw_write_enable)
            begin
                mode_nxt.erase_setup =
                    wr_byte[flash_ctrl_pkg::ERASE_SETUP_BIT];
                mode_nxt.program_setup =
                    wr_byte[flash_ctrl_pkg::PROGRAM_SETUP_BIT];
                mode_nxt.erase_verify =
                    wr_byte[flash_ctrl_pkg::ERASE_VERIFY_BIT];
                mode_nxt.program_verify =
                    wr_byte[flash_ctrl_pkg::PROGRAM_VERIFY_BIT];
                // Mode bits clearable whenever writes are enabled; set needs its setup bit
                mode_nxt.erase_mode =
                    wr_byte[flash_ctrl_pkg::ERASE_MODE_BIT]
                    & mode_r.erase_setup;
                mode_nxt.program_mode =
                    wr_byte[flash_ctrl_pkg::PROGRAM_MODE_BIT]
                    & mode_r.program_setup;
            end
        end
        // Losing the pin drops every enabled bit at once
        if (!hw_write_enable)
        begin
            mode_nxt = '0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_r <= '0;
        end
        else if (watchdog_reset | standby_init)
        begin
            mode_r <= '0;
        end
        else
        begin
            mode_r <= mode_nxt;
        end
    end

    // Pin mirror is registered so reads are glitch free
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hw_we_r <= 1'b0;
        end
        else
        begin
            hw_we_r <= hw_write_enable;
        end
    end

    // ------------------------------------------------------------
    // Error protection
    // ------------------------------------------------------------
    logic pe_active;
    logic error_set;

    assign pe_active = mode_r.program_mode | mode_r.erase_mode;
    assign error_set = pe_active & (cpu_event.flash_read
        | (cpu_event.exception_start & ~cpu_event.exempt_exception)
        | cpu_event.sleep_exec | sw_standby
        | cpu_event.bus_release);

    // Software standby also sets the flag; only hw paths clear it
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            error_r <= 1'b0;
        end
        else if (watchdog_reset | hw_standby)
        begin
            error_r <= 1'b0;
        end
        else if (error_set)
        begin
            error_r <= 1'b1;
        end
    end

    assign flash_error = error_r;

    // ------------------------------------------------------------
    // Flash array control
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            array_ctrl <= '0;
        end
        else
        begin
            array_ctrl.program_active <= mode_nxt.program_mode
                & ~error_r & ~error_set;
            array_ctrl.erase_active <= mode_nxt.erase_mode
                & ~error_r & ~error_set;
            array_ctrl.program_verify_active <=
                mode_nxt.program_verify;
            array_ctrl.erase_verify_active <=
                mode_nxt.erase_verify;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            readdata_r <= '0;
        end
        else if (avs_read & ~access_done)
        begin
            case (avs_address)
                flash_ctrl_pkg::MODE_CONTROL_ADDR:
                begin
                    readdata_r <= flash_enabled
                        ? {24'h000000, hw_we_r, mode_r}
                        : {24'h000000,
                           flash_ctrl_pkg::DISABLED_READ_VALUE};
                end
                flash_ctrl_pkg::ERROR_STATUS_ADDR:
                begin
                    readdata_r <= flash_enabled
                        ? {24'h000000, error_r, 7'h00}
                        : {24'h000000,
                           flash_ctrl_pkg::DISABLED_READ_VALUE};
                end
                default:
                begin
                    readdata_r <= flash_ctrl_pkg::UNMAPPED_READ_VALUE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence setup_then_mode_s;
        !array_ctrl.program_active ##1 array_ctrl.program_active;
    endsequence

    prog_needs_setup_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        setup_then_mode_s |-> $past(mode_r.program_setup))
        else $error("program started without setup");

    erase_needs_setup_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        $rose(mode_r.erase_mode) |-> $past(mode_r.erase_setup)
            && $past(mode_r.sw_write_enable))
        else $error("erase mode set without setup");

    sw_needs_pin_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        $rose(mode_r.sw_write_enable) |-> $past(hw_write_enable))
        else $error("software enable set without pin");

    setup_needs_sw_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        $rose(mode_r.program_setup) |-> $past(mode_r.sw_write_enable))
        else $error("setup bit set without software enable");

    error_sticky_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        error_r && !watchdog_reset && !hw_standby |=> error_r)
        else $error("error flag cleared without reset");

    error_sets_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        pe_active && cpu_event.flash_read && !watchdog_reset
            && !hw_standby |=> error_r)
        else $error("flash read during program did not set error");

    error_blocks_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        error_r |=> !array_ctrl.program_active
            && !array_ctrl.erase_active)
        else $error("array active under error protection");

    status_reserved_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        avs_read && !avs_waitrequest
            && avs_address == flash_ctrl_pkg::ERROR_STATUS_ADDR
            |-> avs_readdata[6:0] == 7'h00)
        else $error("status reserved bits not zero");

    disabled_read_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        avs_read && !avs_waitrequest && !flash_enabled
            && !$past(flash_enabled) |-> avs_readdata == 32'h00000000)
        else $error("disabled flash read not zero");

    // Erase entry has the same two-step shape as programming
    sequence erase_rise_s;
        !array_ctrl.erase_active ##1 array_ctrl.erase_active;
    endsequence

    erase_needs_chain_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        erase_rise_s |-> $past(mode_r.erase_setup)
            && $past(mode_r.sw_write_enable))
        else $error("erase started without the enable chain");

    // Mirror lags the pin by one edge, so the edge after reset is skipped
    pin_mirror_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        nrst && $past(nrst) |-> hw_we_r == $past(hw_write_enable))
        else $error("bit 7 does not follow the pin");

    pin_low_clears_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        !hw_write_enable |=> mode_r == '0)
        else $error("control bits kept with pin low");

    disabled_write_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        !flash_enabled && hw_write_enable && !watchdog_reset
            && !standby_init |=> $stable(mode_r))
        else $error("control changed while flash disabled");

    standby_clears_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        watchdog_reset || standby_init |=> mode_r == '0)
        else $error("control bits kept over standby");

    exempt_no_error_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        pe_active && !error_r && cpu_event.exception_start
            && cpu_event.exempt_exception && !cpu_event.flash_read
            && !cpu_event.sleep_exec && !cpu_event.bus_release
            && !sw_standby |=> !error_r)
        else $error("exempt exception set the error flag");

    exception_sets_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        pe_active && cpu_event.exception_start
            && !cpu_event.exempt_exception && !watchdog_reset
            && !hw_standby |=> error_r)
        else $error("exception during program did not set error");

    sleep_sets_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        pe_active && (cpu_event.sleep_exec || cpu_event.bus_release
            || sw_standby) && !watchdog_reset && !hw_standby |=> error_r)
        else $error("sleep or bus release did not set error");

    error_clears_a: assert property (@(posedge core_clk)
        disable iff (!nrst)
        watchdog_reset || hw_standby |=> !error_r)
        else $error("error flag survived reset or hw standby");

endmodule

// ===== verification/cpu_bus_model.sv
module cpu_bus_model (
    input wire logic core_clk,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    output logic [1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    output flash_ctrl_pkg::cpu_event_type cpu_event
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        avs_address = 2'h3;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'hFFFFFFFF;
        avs_byteenable = 4'h0;
        cpu_event = '0;
    end

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Request stays put until waitrequest is seen low at an edge
    task automatic wait_answer();
        int k;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 20);
        if (avs_waitrequest !== 1'b0)
        begin
            $display("BAD %0t bus answer missing", $time);
            flash_program_erase_control_tb_top.num_errors++;
            flash_program_erase_control_tb_top.tally_and_finish();
        end
    endtask

    // Released address and data lines flip, so a stale value can never look valid
    task automatic release_bus();
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~avs_address;
        avs_writedata <= ~avs_writedata;
        avs_byteenable <= 4'h0;
        @(posedge core_clk);
    endtask

    // Callers change one of bits 6..0 per control-register write
    task automatic write_reg(input logic [1:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= 4'h1;
        avs_write <= 1'b1;
        wait_answer();
        release_bus();
    endtask

    task automatic read_reg(input logic [1:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read <= 1'b1;
        wait_answer();
        d = avs_readdata;
        release_bus();
    endtask

    // Sleep and bus release are only raised in program mode to trip the error flag; a flash
    // read in erase verify and an exempt exception in program mode must leave it clear
    task automatic pulse_event(input flash_ctrl_pkg::cpu_event_type e);
        cpu_event <= e;
        @(posedge core_clk);
        cpu_event <= '0;
        @(posedge core_clk);
    endtask
endmodule

// ===== verification/flash_program_erase_control_tb_top.sv
module flash_program_erase_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic core_clk, nrst, watchdog_reset, hw_standby, sw_standby;
    logic flash_enabled, hw_write_enable, avs_read, avs_write;
    logic avs_waitrequest, flash_error;
    logic [1:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    flash_ctrl_pkg::cpu_event_type cpu_event;
    flash_ctrl_pkg::array_ctrl_type array_ctrl;
    int num_errors = 0;
    int comparisons = 0;
    logic [4:0] trip [4] = '{5'h10, 5'h08, 5'h02, 5'h01};

    flash_program_erase_control dut (.core_clk(core_clk), .nrst(nrst),
        .watchdog_reset(watchdog_reset), .hw_standby(hw_standby),
        .sw_standby(sw_standby), .flash_enabled(flash_enabled),
        .hw_write_enable(hw_write_enable), .cpu_event(cpu_event),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .array_ctrl(array_ctrl),
        .flash_error(flash_error));

    cpu_bus_model u_cpu (.core_clk(core_clk), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .cpu_event(cpu_event));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    task automatic rd(input logic [1:0] a, input logic [31:0] e);
        logic [31:0] d;
        u_cpu.read_reg(a, d);
        check(d, e, "register read");
    endtask

    // Pin changes reach bit 7 one edge late, so two edges are allowed
    task automatic settle();
        repeat (2) @(posedge core_clk);
    endtask

    task automatic chk_arr(input logic [3:0] e);
        settle();
        check({28'h0000000, array_ctrl}, {28'h0000000, e}, "array ctrl");
    endtask

    task automatic chk_err(input logic e);
        settle();
        check({31'h0, flash_error}, {31'h0, e}, "error flag");
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        $display("BAD %0t run too long", $time);
        num_errors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        nrst = 1'b0;
        watchdog_reset = 1'b0;
        hw_standby = 1'b0;
        sw_standby = 1'b0;
        flash_enabled = 1'b1;
        hw_write_enable = 1'b1;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        settle();
        rd(2'h0, 32'h80);
        rd(2'h1, 32'h00);
        rd(2'h2, 32'h00);
        u_cpu.write_reg(2'h0, 8'h20);
        rd(2'h0, 32'h80);
        hw_write_enable <= 1'b0;
        settle();
        rd(2'h0, 32'h00);
        u_cpu.write_reg(2'h0, 8'h40);
        rd(2'h0, 32'h00);
        hw_write_enable <= 1'b1;
        settle();
        u_cpu.write_reg(2'h0, 8'hC0);
        u_cpu.write_reg(2'h0, 8'hC2);
        rd(2'h0, 32'hC0);
        u_cpu.write_reg(2'h0, 8'hC1);
        rd(2'h0, 32'hC0);
        u_cpu.write_reg(2'h0, 8'hC8);
        chk_arr(4'h1);
        u_cpu.pulse_event(5'h10);
        chk_err(1'b0);
        u_cpu.write_reg(2'h0, 8'hC0);
        u_cpu.write_reg(2'h0, 8'hC4);
        chk_arr(4'h2);
        u_cpu.write_reg(2'h0, 8'hC0);
        u_cpu.write_reg(2'h0, 8'hE0);
        u_cpu.write_reg(2'h0, 8'hE2);
        rd(2'h0, 32'hE2);
        chk_arr(4'h4);
        u_cpu.write_reg(2'h0, 8'hE0);
        for (int i = 0; i < 4; i++)
        begin
            u_cpu.write_reg(2'h0, 8'hC0);
            u_cpu.write_reg(2'h0, 8'hD0);
            u_cpu.write_reg(2'h0, 8'hD1);
            chk_arr(4'h8);
            u_cpu.pulse_event(5'h0C);
            chk_err(1'b0);
            u_cpu.pulse_event(trip[i]);
            chk_err(1'b1);
            chk_arr(4'h0);
            u_cpu.write_reg(2'h1, 8'h7F);
            rd(2'h1, 32'h80);
            sw_standby <= 1'b1;
            @(posedge core_clk);
            sw_standby <= 1'b0;
            chk_err(1'b1);
            rd(2'h0, 32'h80);
            case (i)
                0: watchdog_reset <= 1'b1;
                1: hw_standby <= 1'b1;
                default: nrst <= 1'b0;
            endcase
            @(posedge core_clk);
            watchdog_reset <= 1'b0;
            hw_standby <= 1'b0;
            nrst <= 1'b1;
            chk_err(1'b0);
            rd(2'h1, 32'h00);
        end
        flash_enabled <= 1'b0;
        rd(2'h0, 32'h00);
        rd(2'h1, 32'h00);
        u_cpu.write_reg(2'h0, 8'h40);
        flash_enabled <= 1'b1;
        rd(2'h0, 32'h80);
        tally_and_finish();
    end
endmodule
